/* rtl/sct_ms_tick.sv */
`timescale 1ns/1ps
// Free-running millisecond tick, restartable so a fresh count is aligned
module sct_ms_tick (
	input  wire logic core_clk,   // System clock
	input  wire logic rstn,       // Async reset, active low
	input  wire logic restart,    // Realign the tick phase
	output logic      msTick      // One-cycle pulse per millisecond
);
	localparam logic [13:0] LAST =
		14'(sct_pkg::TICKS_PER_MS - 1);
	logic [13:0] cnt_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 14'h0000;
		end else if (restart || cnt_reg == LAST) begin
			cnt_reg <= 14'h0000;
		end else begin
			cnt_reg <= cnt_reg + 14'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			msTick <= 1'b0;
		end else begin
			msTick <= !restart && cnt_reg == LAST;
		end
	end
endmodule : sct_ms_tick

/* rtl/sct_pkg.sv */
package sct_pkg;
	// Printed offsets are not all multiples of four: they are indices
	localparam logic [11:0] IDX_FB_DIV     = 12'h200;
	localparam logic [11:0] IDX_INPUT_CFG  = 12'h201;
	localparam logic [11:0] IDX_REF_B0     = 12'h202;
	localparam logic [11:0] IDX_REF_B1     = 12'h203;
	localparam logic [11:0] IDX_REF_B2     = 12'h204;
	localparam logic [11:0] IDX_REF_B3     = 12'h205;
	localparam logic [11:0] IDX_STAB_B0    = 12'h206;
	localparam logic [11:0] IDX_STAB_B1    = 12'h207;
	localparam logic [11:0] IDX_STAB_B2    = 12'h208;
	localparam logic [11:0] IDX_COMMIT     = 12'h00f;
	localparam logic [11:0] IDX_STATUS     = 12'h210;
	localparam int          BYTE_SHIFT     = 2;
	localparam int          XTAL_BIT       = 3;
	localparam int          PRESC_LSB      = 1;
	localparam int          DOUBLER_BIT    = 0;
	localparam logic [7:0]  CFG_RESET      = 8'h08;
	localparam logic [7:0]  CFG_MASK       = 8'h0f;
	localparam logic [7:0]  NIBBLE_MASK    = 8'h0f;
	localparam logic [7:0]  COMMIT_CODE    = 8'h01;
	localparam logic [19:0] STAB_RESET     = 20'h00032;
	localparam logic [27:0] REF_RESET      = 28'h0000000;
	localparam logic [7:0]  FB_DIV_RESET   = 8'h00;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam int          CLK_HZ         = 10000000;
	localparam int          MS_PER_S       = 1000;
	localparam int          TICKS_PER_MS   = CLK_HZ / MS_PER_S;
	typedef enum logic [1:0] {
		ST_HALT,
		ST_WAIT_LOCK,
		ST_COUNT,
		ST_STABLE
	} sct_stab_t;
endpackage : sct_pkg

/* rtl/sct_sys_timebase_ctrl.sv */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - Bit 3 set selects crystal amplifier, default; clear takes external clock.
// - Two-bit prescaler field: 00 /1 default, 01 /2, 10 /4, 11 /8.
// - Bit 0 enables the input doubler; cleared by default.
// - 28-bit reference frequency in four bytes, LSB first, resets zero.
// - Stable only after lock held for the period; default 50 ms.
// - Any write to a stability-period byte resets the timer.
// - After such write, counting restarts on commit strobe (0x01 to commit).
// - Stability period is 20-bit milliseconds over three bytes, LSB first.
module sct_sys_timebase_ctrl (
	input  wire logic        core_clk,        // System clock, 10 MHz
	input  wire logic        rstn,            // Async reset, active low
	input  wire logic        hsel,            // AHB slave select
	input  wire logic [31:0] haddr,           // AHB address
	input  wire logic [1:0]  htrans,          // AHB transfer type
	input  wire logic        hwrite,          // AHB write
	input  wire logic [2:0]  hsize,           // AHB size
	input  wire logic [31:0] hwdata,          // AHB write data
	input  wire logic        hready,          // AHB bus ready
	output logic [31:0]      hrdata,          // AHB read data
	output logic             hreadyout,       // AHB slave ready
	output logic             hresp,           // AHB response, OKAY
	input  wire logic        pllLockPin,      // Timebase PLL lock, async
	output logic             crystalAmpSelect, // Crystal amplifier on
	output logic [1:0]       inputPrescaler,  // Input prescaler code
	output logic             inputDoubler,    // Input doubler on
	output logic [7:0]       feedbackDivider, // Timebase PLL feedback div
	output logic [27:0]      refFreqHz,       // Nominal reference, Hz
	output logic             timebaseStable   // Timebase declared stable
);
	logic [7:0]              cfg_reg;
	logic [7:0]              fbDiv_reg;
	logic [27:0]             refFreq_reg;
	logic [19:0]             stab_reg;
	logic                    wrPend_reg;
	logic [11:0]             wrIdx_reg;
	logic [31:0]             hrdata_next;
	logic                    lockMeta_reg;
	logic                    lockSync_reg;
	logic [19:0]             msCount_reg;
	sct_pkg::sct_stab_t      state_reg;
	logic                    msTick;
	logic                    addrOk;
	logic                    wrEn;
	logic                    stabWrite;
	logic                    commitStrobe;
	logic                    tickRestart;
	logic [11:0]             addrIdx;

	assign addrIdx = haddr[sct_pkg::BYTE_SHIFT +: 12];
	assign addrOk = hsel && hready && htrans == sct_pkg::HTRANS_NONSEQ;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Latch write address phase; data follows in the next cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPend_reg <= 1'b0;
			wrIdx_reg <= 12'h000;
		end else begin
			wrPend_reg <= addrOk && hwrite;
			wrIdx_reg <= addrIdx;
		end
	end

	assign wrEn = wrPend_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= sct_pkg::CFG_RESET;
		end else if (wrEn && wrIdx_reg == sct_pkg::IDX_INPUT_CFG) begin
			cfg_reg <= hwdata[7:0] & sct_pkg::CFG_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fbDiv_reg <= sct_pkg::FB_DIV_RESET;
		end else if (wrEn && wrIdx_reg == sct_pkg::IDX_FB_DIV) begin
			fbDiv_reg <= hwdata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			refFreq_reg <= sct_pkg::REF_RESET;
		end else if (wrEn) begin
			case (wrIdx_reg)
				sct_pkg::IDX_REF_B0: refFreq_reg[7:0] <= hwdata[7:0];
				sct_pkg::IDX_REF_B1: refFreq_reg[15:8] <= hwdata[7:0];
				sct_pkg::IDX_REF_B2: refFreq_reg[23:16] <= hwdata[7:0];
				sct_pkg::IDX_REF_B3: refFreq_reg[27:24] <= hwdata[3:0];
				default: refFreq_reg <= refFreq_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stab_reg <= sct_pkg::STAB_RESET;
		end else if (wrEn) begin
			case (wrIdx_reg)
				sct_pkg::IDX_STAB_B0: stab_reg[7:0] <= hwdata[7:0];
				sct_pkg::IDX_STAB_B1: stab_reg[15:8] <= hwdata[7:0];
				sct_pkg::IDX_STAB_B2: stab_reg[19:16] <= hwdata[3:0];
				default: stab_reg <= stab_reg;
			endcase
		end
	end

	assign stabWrite = wrEn && (wrIdx_reg == sct_pkg::IDX_STAB_B0
		|| wrIdx_reg == sct_pkg::IDX_STAB_B1
		|| wrIdx_reg == sct_pkg::IDX_STAB_B2);
	assign commitStrobe = wrEn && wrIdx_reg == sct_pkg::IDX_COMMIT
		&& hwdata[7:0] == sct_pkg::COMMIT_CODE;

	// Read data registered at the address phase
	always_comb begin
		hrdata_next = 32'h00000000;
		case (addrIdx)
			sct_pkg::IDX_FB_DIV:    hrdata_next[7:0] = fbDiv_reg;
			sct_pkg::IDX_INPUT_CFG: hrdata_next[7:0] = cfg_reg;
			sct_pkg::IDX_REF_B0:    hrdata_next[7:0] = refFreq_reg[7:0];
			sct_pkg::IDX_REF_B1:    hrdata_next[7:0] = refFreq_reg[15:8];
			sct_pkg::IDX_REF_B2:    hrdata_next[7:0] = refFreq_reg[23:16];
			sct_pkg::IDX_REF_B3:    hrdata_next[3:0] = refFreq_reg[27:24];
			sct_pkg::IDX_STAB_B0:   hrdata_next[7:0] = stab_reg[7:0];
			sct_pkg::IDX_STAB_B1:   hrdata_next[7:0] = stab_reg[15:8];
			sct_pkg::IDX_STAB_B2:   hrdata_next[3:0] = stab_reg[19:16];
			sct_pkg::IDX_STATUS:    hrdata_next[1:0] =
				{lockSync_reg, timebaseStable};
			default:                hrdata_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
		end else if (addrOk && !hwrite) begin
			hrdata <= hrdata_next;
		end
	end

	// Lock pin synchroniser
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lockMeta_reg <= 1'b0;
			lockSync_reg <= 1'b0;
		end else begin
			lockMeta_reg <= pllLockPin;
			lockSync_reg <= lockMeta_reg;
		end
	end

	assign tickRestart = state_reg != sct_pkg::ST_COUNT;

	sct_ms_tick u_tick (
		.core_clk (core_clk),
		.rstn     (rstn),
		.restart  (tickRestart),
		.msTick   (msTick)
	);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= sct_pkg::ST_WAIT_LOCK;
		end else if (stabWrite) begin
			state_reg <= sct_pkg::ST_HALT;
		end else begin
			case (state_reg)
				sct_pkg::ST_HALT:
					if (commitStrobe) begin
						state_reg <= sct_pkg::ST_WAIT_LOCK;
					end
				sct_pkg::ST_WAIT_LOCK:
					if (lockSync_reg) begin
						state_reg <= sct_pkg::ST_COUNT;
					end
				sct_pkg::ST_COUNT:
					if (!lockSync_reg) begin
						state_reg <= sct_pkg::ST_WAIT_LOCK;
					end else if (msCount_reg >= stab_reg) begin
						state_reg <= sct_pkg::ST_STABLE;
					end
				sct_pkg::ST_STABLE:
					if (!lockSync_reg) begin
						state_reg <= sct_pkg::ST_WAIT_LOCK;
					end
				default: state_reg <= sct_pkg::ST_WAIT_LOCK;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			msCount_reg <= 20'h00000;
		end else if (state_reg != sct_pkg::ST_COUNT || stabWrite
			|| !lockSync_reg) begin
			msCount_reg <= 20'h00000;
		end else if (msTick && msCount_reg != 20'hfffff) begin
			msCount_reg <= msCount_reg + 20'h00001;
		end
	end

	assign timebaseStable = state_reg == sct_pkg::ST_STABLE;
	assign crystalAmpSelect = cfg_reg[sct_pkg::XTAL_BIT];
	assign inputPrescaler = cfg_reg[sct_pkg::PRESC_LSB +: 2];
	assign inputDoubler = cfg_reg[sct_pkg::DOUBLER_BIT];
	assign feedbackDivider = fbDiv_reg;
	assign refFreqHz = refFreq_reg;

	// Assertions
	property p_stable_needs_lock;
		@(posedge core_clk) disable iff (!rstn)
		timebaseStable |-> $past(lockSync_reg);
	endproperty
	a_stable_needs_lock: assert property (p_stable_needs_lock)
		else $error("stable without lock");

	property p_write_resets;
		@(posedge core_clk) disable iff (!rstn)
		stabWrite |=> !timebaseStable && msCount_reg == 20'h00000;
	endproperty
	a_write_resets: assert property (p_write_resets)
		else $error("period write did not reset timer");

	sequence s_halted;
		state_reg == sct_pkg::ST_HALT && !commitStrobe && !stabWrite;
	endsequence
	property p_halt_holds;
		@(posedge core_clk) disable iff (!rstn)
		s_halted |=> state_reg == sct_pkg::ST_HALT;
	endproperty
	a_halt_holds: assert property (p_halt_holds)
		else $error("timer left halt without commit");

	property p_commit_restarts;
		@(posedge core_clk) disable iff (!rstn)
		state_reg == sct_pkg::ST_HALT && commitStrobe && !stabWrite
			|=> state_reg == sct_pkg::ST_WAIT_LOCK;
	endproperty
	a_commit_restarts: assert property (p_commit_restarts)
		else $error("commit did not restart timer");

	property p_loss_drops;
		@(posedge core_clk) disable iff (!rstn)
		!lockSync_reg |=> !timebaseStable && msCount_reg == 20'h00000;
	endproperty
	a_loss_drops: assert property (p_loss_drops)
		else $error("lock loss kept stable or count");

	property p_cfg_fields;
		@(posedge core_clk) disable iff (!rstn)
		wrEn && wrIdx_reg == sct_pkg::IDX_INPUT_CFG
			|=> crystalAmpSelect == $past(hwdata[sct_pkg::XTAL_BIT]);
	endproperty
	a_cfg_fields: assert property (p_cfg_fields)
		else $error("config fields misplaced");

	property p_cfg_write;
		@(posedge core_clk) disable iff (!rstn)
		wrEn && wrIdx_reg == sct_pkg::IDX_INPUT_CFG
			|=> inputDoubler == $past(hwdata[0])
			&& inputPrescaler == $past(hwdata[2:1]);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("config write lost");

	property p_ref_top;
		@(posedge core_clk) disable iff (!rstn)
		wrEn && wrIdx_reg == sct_pkg::IDX_REF_B3
			|=> refFreqHz[27:24] == $past(hwdata[3:0]);
	endproperty
	a_ref_top: assert property (p_ref_top)
		else $error("reference top nibble wrong");

	property p_stab_top;
		@(posedge core_clk) disable iff (!rstn)
		wrEn && wrIdx_reg == sct_pkg::IDX_STAB_B2
			|=> stab_reg[19:16] == $past(hwdata[3:0]);
	endproperty
	a_stab_top: assert property (p_stab_top)
		else $error("period top nibble wrong");

	property p_stable_when_due;
		@(posedge core_clk) disable iff (!rstn)
		state_reg == sct_pkg::ST_COUNT && lockSync_reg && !stabWrite
			&& msCount_reg >= stab_reg |=> timebaseStable;
	endproperty
	a_stable_when_due: assert property (p_stable_when_due)
		else $error("stable not declared on expiry");

	property p_stable_holds;
		@(posedge core_clk) disable iff (!rstn)
		timebaseStable && lockSync_reg && !stabWrite |=> timebaseStable;
	endproperty
	a_stable_holds: assert property (p_stable_holds)
		else $error("stable dropped while locked");

	property p_count_holds;
		@(posedge core_clk) disable iff (!rstn)
		state_reg == sct_pkg::ST_COUNT && lockSync_reg && !stabWrite
			&& !msTick |=> msCount_reg == $past(msCount_reg);
	endproperty
	a_count_holds: assert property (p_count_holds)
		else $error("count moved without tick");

	property p_count_from_zero;
		@(posedge core_clk) disable iff (!rstn)
		state_reg == sct_pkg::ST_WAIT_LOCK && lockSync_reg && !stabWrite
			|=> state_reg == sct_pkg::ST_COUNT
			&& msCount_reg == 20'h00000;
	endproperty
	a_count_from_zero: assert property (p_count_from_zero)
		else $error("relock did not count from zero");

	property p_ref_low;
		@(posedge core_clk) disable iff (!rstn)
		wrEn && wrIdx_reg == sct_pkg::IDX_REF_B0
			|=> refFreqHz[7:0] == $past(hwdata[7:0]);
	endproperty
	a_ref_low: assert property (p_ref_low)
		else $error("reference low byte wrong");

	property p_stab_low;
		@(posedge core_clk) disable iff (!rstn)
		wrEn && wrIdx_reg == sct_pkg::IDX_STAB_B0
			|=> stab_reg[7:0] == $past(hwdata[7:0]);
	endproperty
	a_stab_low: assert property (p_stab_low)
		else $error("period low byte wrong");

	property p_status_read;
		@(posedge core_clk) disable iff (!rstn)
		addrOk && !hwrite && addrIdx == sct_pkg::IDX_STATUS
			|=> hrdata[1:0] == $past({lockSync_reg, timebaseStable});
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read wrong");
endmodule : sct_sys_timebase_ctrl

/* tb/sct_lock_model.sv */
`timescale 1ns/1ps
// Oscillator and timebase PLL as seen from the lock pin
module sct_lock_model #(
	parameter int LOCK_DLY = 40
) (
	input  wire logic       core_clk,        // System clock
	input  wire logic       rstn,            // Reset, active low
	input  wire logic       oscOn,           // Oscillator running
	input  wire logic       dutyOk,          // Input duty near half
	input  wire logic       inputDoubler,    // Doubler enabled
	input  wire logic [7:0] feedbackDivider, // Programmed divider
	output logic            pllLockPin       // Lock indication
);
	int   lockCnt_reg;
	logic canLock;
	assign canLock = oscOn && (dutyOk || !inputDoubler) &&
		(feedbackDivider >= 8'h04);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lockCnt_reg <= 0;
		end else if (!canLock) begin
			lockCnt_reg <= 0;
		end else if (lockCnt_reg < LOCK_DLY) begin
			lockCnt_reg <= lockCnt_reg + 1;
		end
	end
	assign pllLockPin = canLock && (lockCnt_reg == LOCK_DLY);
endmodule : sct_lock_model

/* tb/tb_system_clock_config_stability.sv */
`timescale 1ns/1ps
module tb_system_clock_config_stability;
	logic        core_clk = 1'b0;
	logic        rstn     = 1'b0;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [2:0]  hsize    = 3'h2;
	logic [31:0] hwdata   = 32'h0;
	logic        oscOn    = 1'b0;
	logic        dutyOk   = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        pllLockPin;
	logic        xtal;
	logic [1:0]  presc;
	logic        dbl;
	logic [7:0]  fbDiv;
	logic [27:0] refHz;
	logic        stable;
	int          badCount    = 0;
	int          totalChecks = 0;
	logic [11:0] rIdx [11] = '{12'h200, 12'h201, 12'h202, 12'h203,
		12'h204, 12'h205, 12'h206, 12'h207, 12'h208, 12'h210, 12'h300};
	logic [7:0]  rVal [11] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00};

	always #50 core_clk = ~core_clk;

	sct_sys_timebase_ctrl dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .pllLockPin(pllLockPin),
		.crystalAmpSelect(xtal), .inputPrescaler(presc),
		.inputDoubler(dbl), .feedbackDivider(fbDiv), .refFreqHz(refHz),
		.timebaseStable(stable));

	sct_lock_model lock_model (.core_clk(core_clk), .rstn(rstn),
		.oscOn(oscOn), .dutyOk(dutyOk), .inputDoubler(dbl),
		.feedbackDivider(fbDiv), .pllLockPin(pllLockPin));

	task automatic endSim;
		$display("Checks %0d, mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : endSim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk

	// One single AHB transfer, called right after a rising edge
	task automatic ahb(input logic [11:0] idx, input logic wr,
		input logic [7:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= sct_pkg::HTRANS_NONSEQ;
		haddr  <= {18'h0, idx, 2'b00};
		hwrite <= wr;
		hsize  <= 3'h2;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		logic [31:0] x;
		ahb(idx, 1'b1, d, x);
	endtask : wr

	task automatic rchk(input logic [11:0] idx, input logic [7:0] e);
		logic [31:0] x;
		ahb(idx, 1'b0, 8'h00, x);
		chk(x, {24'h0, e});
	endtask : rchk

	task automatic waitCyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : waitCyc

	// Bounded wait for the stable flag
	task automatic waitStable;
		int k;
		for (k = 0; k < 3000 && stable !== 1'b1; k++) @(posedge core_clk);
	endtask : waitStable

	initial begin
		waitCyc(60000);
		badCount++;
		endSim();
	end

	initial begin
		waitCyc(8);
		rstn <= 1'b1;
		for (int i = 0; i < 11; i++) rchk(rIdx[i], rVal[i]);
		chk({28'h0, xtal, presc, dbl}, 32'h8);
		chk({4'h0, refHz}, 32'h0);
		for (int i = 0; i < 16; i++) begin
			wr(sct_pkg::IDX_INPUT_CFG, {4'hf, i[3:0]});
			rchk(sct_pkg::IDX_INPUT_CFG, {4'h0, i[3:0]});
			chk({28'h0, xtal, presc, dbl}, {28'h0, i[3:0]});
		end
		wr(sct_pkg::IDX_REF_B0, 8'h78);
		wr(sct_pkg::IDX_REF_B1, 8'h56);
		wr(sct_pkg::IDX_REF_B2, 8'h34);
		wr(sct_pkg::IDX_REF_B3, 8'hf2);
		rchk(sct_pkg::IDX_REF_B3, 8'h02);
		chk({4'h0, refHz}, 32'h2345678);
		wr(sct_pkg::IDX_FB_DIV, 8'h04);
		rchk(sct_pkg::IDX_FB_DIV, 8'h04);
		chk({24'h0, fbDiv}, 32'h04);
		// Doubler on with poor duty cycle keeps the loop unlocked
		wr(sct_pkg::IDX_INPUT_CFG, 8'h09);
		oscOn <= 1'b1;
		wr(sct_pkg::IDX_STAB_B0, 8'h01);
		wr(sct_pkg::IDX_STAB_B1, 8'h00);
		wr(sct_pkg::IDX_STAB_B2, 8'hf0);
		rchk(sct_pkg::IDX_STAB_B2, 8'h00);
		wr(sct_pkg::IDX_INPUT_CFG, 8'h08);
		waitCyc(12000);
		chk({31'h0, stable}, 32'h0);
		wr(sct_pkg::IDX_INPUT_CFG, 8'h09);
		wr(sct_pkg::IDX_COMMIT, sct_pkg::COMMIT_CODE);
		waitCyc(12000);
		chk({31'h0, stable}, 32'h0);
		wr(sct_pkg::IDX_INPUT_CFG, 8'h08);
		waitCyc(9000);
		chk({31'h0, stable}, 32'h0);
		waitStable();
		chk({31'h0, stable}, 32'h1);
		rchk(sct_pkg::IDX_STATUS, 8'h03);
		oscOn <= 1'b0;
		waitCyc(10);
		chk({31'h0, stable}, 32'h0);
		oscOn <= 1'b1;
		waitCyc(9000);
		chk({31'h0, stable}, 32'h0);
		waitStable();
		chk({31'h0, stable}, 32'h1);
		wr(sct_pkg::IDX_STAB_B1, 8'h00);
		waitCyc(2);
		chk({31'h0, stable}, 32'h0);
		endSim();
	end
endmodule : tb_system_clock_config_stability
